// ===== hdl/cfr_pkg.sv
package cfr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Access port widths and coordinates of the two feature words
    localparam int CFR_DATA_W = 32;
    localparam int CFR_NUM_W = 5;
    localparam int CFR_SEL_W = 3;
    localparam logic [CFR_NUM_W-1:0] CFR_FEAT_REG_NUM = 5'h10;
    localparam logic [CFR_SEL_W-1:0] CFR_SEL_WORD_ONE = 3'h1;
    localparam logic [CFR_SEL_W-1:0] CFR_SEL_WORD_THREE = 3'h3;
    localparam logic [CFR_DATA_W-1:0] CFR_ZERO_WORD = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // First feature word fields
    localparam int CFR_W1_NEXT_BIT = 31;
    localparam int CFR_W1_ZERO_HI = 30;
    localparam int CFR_W1_ZERO_LO = 5;
    localparam int CFR_W1_PERF_BIT = 4;
    localparam int CFR_W1_WATCH_BIT = 3;
    localparam int CFR_W1_LCOMP_BIT = 2;
    localparam int CFR_W1_DEBUG_BIT = 1;
    localparam int CFR_W1_FLOAT_BIT = 0;
    localparam logic CFR_W1_NEXT_VAL = 1'b1;
    localparam logic CFR_PERF_COUNTER_PRESENT = 1'b1;
    localparam logic CFR_WATCH_REG_PRESENT = 1'b0;
    localparam logic CFR_LEGACY_COMPRESS_PRESENT = 1'b0;
    localparam logic CFR_DEBUG_EXT_PRESENT = 1'b1;
    localparam logic CFR_FLOAT_UNIT_PRESENT = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Third feature word fields
    localparam int CFR_W3_TOP_BIT = 31;
    localparam int CFR_W3_PRIO_HI = 22;
    localparam int CFR_W3_PRIO_LO = 21;
    localparam int CFR_W3_ARCH_HI = 20;
    localparam int CFR_W3_ARCH_LO = 18;
    localparam int CFR_W3_MCU_BIT = 17;
    localparam int CFR_W3_EXC_BIT = 16;
    localparam int CFR_W3_ISET_HI = 15;
    localparam int CFR_W3_ISET_LO = 14;
    localparam int CFR_W3_ULR_BIT = 13;
    localparam int CFR_W3_INHIB_BIT = 12;
    localparam int CFR_W3_FLOW_BIT = 8;
    localparam int CFR_W3_EIC_BIT = 6;
    localparam int CFR_W3_VEC_BIT = 5;
    localparam int CFR_W3_PAGE_BIT = 4;
    localparam int CFR_W3_DMAP_BIT = 3;
    localparam int CFR_W3_TRACE_BIT = 0;
    localparam logic CFR_W3_TOP_VAL = 1'b0;
    localparam logic [1:0] CFR_PRIORITY_FIELD_WIDTH = 2'h1;
    localparam logic [2:0] CFR_COMPRESSED_ARCH_REVISION = 3'h0;
    localparam logic CFR_MCU_EXT_PRESENT = 1'b1;
    localparam logic CFR_EXCEPTION_ENTRY_INSTR_SET = 1'b1;
    localparam logic [1:0] CFR_INSTR_SET_AVAIL = 2'h1;
    localparam logic CFR_USER_LOCAL_REG_PRESENT = 1'b1;
    localparam logic CFR_READ_EXEC_INHIBIT_PRESENT = 1'b1;
    localparam logic CFR_FLOW_TRACE_PRESENT = 1'b0;
    localparam logic CFR_EXT_IRQ_CTRL_SUPPORT = 1'b1;
    localparam logic CFR_VECTORED_IRQ_PRESENT = 1'b1;
    localparam logic CFR_PAGE_SIZE_FLAG = 1'b0;
    localparam logic CFR_DEVICE_MAP_REGION_PRESENT = 1'b1;
    localparam logic CFR_TRACE_LOGIC_PRESENT = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Assembled words; unlisted bits stay zero
    localparam logic [CFR_DATA_W-1:0] CFR_WORD_ONE =
        (32'(CFR_W1_NEXT_VAL) << CFR_W1_NEXT_BIT) |
        (32'(CFR_PERF_COUNTER_PRESENT) << CFR_W1_PERF_BIT) |
        (32'(CFR_WATCH_REG_PRESENT) << CFR_W1_WATCH_BIT) |
        (32'(CFR_LEGACY_COMPRESS_PRESENT) << CFR_W1_LCOMP_BIT) |
        (32'(CFR_DEBUG_EXT_PRESENT) << CFR_W1_DEBUG_BIT) |
        (32'(CFR_FLOAT_UNIT_PRESENT) << CFR_W1_FLOAT_BIT);
    localparam logic [CFR_DATA_W-1:0] CFR_WORD_THREE =
        (32'(CFR_W3_TOP_VAL) << CFR_W3_TOP_BIT) |
        (32'(CFR_PRIORITY_FIELD_WIDTH) << CFR_W3_PRIO_LO) |
        (32'(CFR_COMPRESSED_ARCH_REVISION) << CFR_W3_ARCH_LO) |
        (32'(CFR_MCU_EXT_PRESENT) << CFR_W3_MCU_BIT) |
        (32'(CFR_EXCEPTION_ENTRY_INSTR_SET) << CFR_W3_EXC_BIT) |
        (32'(CFR_INSTR_SET_AVAIL) << CFR_W3_ISET_LO) |
        (32'(CFR_USER_LOCAL_REG_PRESENT) << CFR_W3_ULR_BIT) |
        (32'(CFR_READ_EXEC_INHIBIT_PRESENT) << CFR_W3_INHIB_BIT) |
        (32'(CFR_FLOW_TRACE_PRESENT) << CFR_W3_FLOW_BIT) |
        (32'(CFR_EXT_IRQ_CTRL_SUPPORT) << CFR_W3_EIC_BIT) |
        (32'(CFR_VECTORED_IRQ_PRESENT) << CFR_W3_VEC_BIT) |
        (32'(CFR_PAGE_SIZE_FLAG) << CFR_W3_PAGE_BIT) |
        (32'(CFR_DEVICE_MAP_REGION_PRESENT) << CFR_W3_DMAP_BIT) |
        (32'(CFR_TRACE_LOGIC_PRESENT) << CFR_W3_TRACE_BIT);

    ////////////////////////////////////////////////////////////////////////
    // Decoded target of an access
    typedef enum logic [1:0] {
        CFR_TGT_NONE = 2'b00,
        CFR_TGT_ONE = 2'b01,
        CFR_TGT_THREE = 2'b10
    } cfr_target_t;

    typedef struct packed {
        logic [CFR_DATA_W-1:0] rd_data;
        logic rd_valid;
        logic rd_hit;
        logic wr_drop;
    } cfr_state_t;

    localparam cfr_state_t CFR_STATE_RST = '{
        rd_data: CFR_ZERO_WORD,
        rd_valid: 1'b0,
        rd_hit: 1'b0,
        wr_drop: 1'b0
    };

endpackage

// ===== hdl/cfr_rst_sync.sv
module cfr_rst_sync (
    // Clock and raw reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Released reset
    output logic o_rstn_sync
);

    typedef struct packed {
        logic stage_one;
        logic stage_two;
    } cfr_sync_state_t;

    cfr_sync_state_t sync_ff;
    cfr_sync_state_t nxt_sync;

    // Only the second stage reads the first, to let metastability settle
    always_comb begin
        nxt_sync.stage_one = 1'b1;
        nxt_sync.stage_two = sync_ff.stage_one;
    end

    // Assert at once, release only after two clean edges
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync_ff <= '0;
        end else begin
            sync_ff <= nxt_sync;
        end
    end

    assign o_rstn_sync = sync_ff.stage_two;

endmodule

// ===== hdl/cfr_top.sv
// Summary of operation
// - First word bit 31 reads one, announcing a further feature word.
// - First word bits 30 to 5 always read zero.
// - First word bit 4 reads one: performance counters present.
// - First word bit 3 reads zero: no watch registers.
// - First word bit 2 reads zero: legacy code compression absent.
// - First word bit 1 reads one: debug extension present.
// - First word bit 0 reads zero: no floating-point unit.
// - Third word bit 31 is hardwired to zero.
// - Third word bits 22 to 21 read 01: eight-bit priority fields.
// - Third word bits 20 to 18 read 000: first compressed release.
// - Third word bit 17 reads one: microcontroller extension present.
// - Third word bit 16 reads one: exceptions enter compressed set.
// - Third word bits 15 to 14 read 01: only compressed set.
// - Third word bit 13 reads one: user-local register present.
// - Third word bit 12 reads one: read and execute inhibit present.
// - Third word bit 8 reads zero: no flow-trace hardware.
// - Third word bit 6 reads one: external interrupt controller support.
// - Third word bit 5 reads one: vectored interrupts present.
// - Third word bit 4 reads zero: four-kilobyte pages.
// - Third word bit 3 reads one: common device map present.
// - Third word bit 0 reads zero: no trace logic.
//
module cfr_top (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Coprocessor register read
    input wire logic i_rd_en,
    input wire logic [cfr_pkg::CFR_NUM_W-1:0] i_rd_num,
    input wire logic [cfr_pkg::CFR_SEL_W-1:0] i_rd_sel,
    // Coprocessor register write
    input wire logic i_wr_en,
    input wire logic [cfr_pkg::CFR_NUM_W-1:0] i_wr_num,
    input wire logic [cfr_pkg::CFR_SEL_W-1:0] i_wr_sel,
    input wire logic [cfr_pkg::CFR_DATA_W-1:0] i_wr_data,
    // Read answer
    output logic [cfr_pkg::CFR_DATA_W-1:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_rd_hit,
    // Write answer
    output logic o_wr_drop
);

    import cfr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release

    logic rstn_sync;

    cfr_rst_sync u_rst_sync (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .o_rstn_sync(rstn_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode shared by the read and write paths

    function automatic cfr_target_t cfr_decode(
        input logic [CFR_NUM_W-1:0] num,
        input logic [CFR_SEL_W-1:0] sel
    );
        cfr_target_t tgt;
        if (num != CFR_FEAT_REG_NUM) begin
            tgt = CFR_TGT_NONE;
        end else if (sel == CFR_SEL_WORD_ONE) begin
            tgt = CFR_TGT_ONE;
        end else if (sel == CFR_SEL_WORD_THREE) begin
            tgt = CFR_TGT_THREE;
        end else begin
            tgt = CFR_TGT_NONE;
        end
        return tgt;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    cfr_state_t state_ff;
    cfr_state_t nxt_state;
    cfr_target_t rd_tgt;
    cfr_target_t wr_tgt;

    assign rd_tgt = cfr_decode(i_rd_num, i_rd_sel);
    assign wr_tgt = cfr_decode(i_wr_num, i_wr_sel);

    always_comb begin
        nxt_state = state_ff;
        nxt_state.rd_valid = i_rd_en;
        nxt_state.rd_hit = 1'b0;
        nxt_state.wr_drop = 1'b0;
        if (i_rd_en) begin
            // Words are constants, so no register can drift after reset
            if (rd_tgt == CFR_TGT_ONE) begin
                nxt_state.rd_data = CFR_WORD_ONE;
                nxt_state.rd_hit = 1'b1;
            end else if (rd_tgt == CFR_TGT_THREE) begin
                nxt_state.rd_data = CFR_WORD_THREE;
                nxt_state.rd_hit = 1'b1;
            end else begin
                // Unmapped selects answer zero so software sees no junk
                nxt_state.rd_data = CFR_ZERO_WORD;
            end
        end
        // Write data is never stored; only the attempt is reported
        if (i_wr_en && (wr_tgt != CFR_TGT_NONE)) begin
            nxt_state.wr_drop = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rstn_sync) begin
        if (!rstn_sync) begin
            state_ff <= CFR_STATE_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_rd_data = state_ff.rd_data;
    assign o_rd_valid = state_ff.rd_valid;
    assign o_rd_hit = state_ff.rd_hit;
    assign o_wr_drop = state_ff.wr_drop;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!rstn_sync);

    logic rd_one;
    logic rd_three;
    assign rd_one = i_rd_en && (rd_tgt == CFR_TGT_ONE);
    assign rd_three = i_rd_en && (rd_tgt == CFR_TGT_THREE);

    sequence s_one;
        rd_one ##1 (o_rd_valid && o_rd_hit);
    endsequence

    sequence s_three;
        rd_three ##1 (o_rd_valid && o_rd_hit);
    endsequence

    AST_W1_NEXT: assert property (s_one |-> o_rd_data[CFR_W1_NEXT_BIT])
        else $error("first word top bit not one");

    AST_W1_ZERO: assert property (
        rd_one |=> o_rd_data[CFR_W1_ZERO_HI:CFR_W1_ZERO_LO] == '0)
        else $error("first word reserved span not zero");

    AST_W1_PERF: assert property (
        rd_one |=> o_rd_valid && o_rd_data[CFR_W1_PERF_BIT])
        else $error("performance counter flag not one");

    AST_W1_WATCH: assert property (
        s_one |-> !o_rd_data[CFR_W1_WATCH_BIT])
        else $error("watch register flag not zero");

    AST_W1_LCOMP: assert property (
        rd_one |=> !o_rd_data[CFR_W1_LCOMP_BIT])
        else $error("legacy compression flag not zero");

    AST_W1_DEBUG: assert property (
        rd_one ##1 o_rd_hit |-> o_rd_data[CFR_W1_DEBUG_BIT])
        else $error("debug extension flag not one");

    AST_W1_FLOAT: assert property (
        rd_one |=> !o_rd_data[CFR_W1_FLOAT_BIT])
        else $error("floating point flag not zero");

    AST_W3_TOP: assert property (
        s_three |-> !o_rd_data[CFR_W3_TOP_BIT])
        else $error("third word top bit not zero");

    AST_W3_PRIO: assert property (
        rd_three |=> o_rd_data[CFR_W3_PRIO_HI:CFR_W3_PRIO_LO] == 2'h1)
        else $error("priority width field not 01");

    AST_W3_ARCH: assert property (
        rd_three |=> o_rd_data[CFR_W3_ARCH_HI:CFR_W3_ARCH_LO] == 3'h0)
        else $error("compressed revision field not 000");

    AST_W3_MCU: assert property (
        rd_three |=> o_rd_data[CFR_W3_MCU_BIT])
        else $error("microcontroller extension flag not one");

    AST_W3_EXC: assert property (
        rd_three |=> o_rd_data[CFR_W3_EXC_BIT])
        else $error("exception entry flag not one");

    AST_W3_ISET: assert property (
        rd_three |=> o_rd_data[CFR_W3_ISET_HI:CFR_W3_ISET_LO] == 2'h1)
        else $error("instruction set field not 01");

    AST_W3_ULR: assert property (
        s_three |-> o_rd_data[CFR_W3_ULR_BIT])
        else $error("user local flag not one");

    AST_W3_INHIB: assert property (
        rd_three |=> o_rd_data[CFR_W3_INHIB_BIT])
        else $error("inhibit flag not one");

    AST_W3_FLOW: assert property (
        rd_three |=> !o_rd_data[CFR_W3_FLOW_BIT])
        else $error("flow trace flag not zero");

    AST_W3_EIC: assert property (
        rd_three |=> o_rd_data[CFR_W3_EIC_BIT])
        else $error("external controller flag not one");

    AST_W3_VEC: assert property (
        rd_three |=> o_rd_data[CFR_W3_VEC_BIT])
        else $error("vectored interrupt flag not one");

    AST_W3_PAGE: assert property (
        rd_three |=> !o_rd_data[CFR_W3_PAGE_BIT])
        else $error("small page flag not zero");

    AST_W3_DMAP: assert property (
        rd_three |=> o_rd_data[CFR_W3_DMAP_BIT])
        else $error("device map flag not one");

    AST_W3_TRACE: assert property (
        rd_three |=> !o_rd_data[CFR_W3_TRACE_BIT])
        else $error("trace logic flag not zero");

    // A write just before a read must not change the word returned
    AST_WR_NO_EFFECT: assert property (
        (i_wr_en && (wr_tgt == CFR_TGT_ONE)) ##1 rd_one
        |=> o_rd_data == CFR_WORD_ONE)
        else $error("write altered the first word");

    AST_WR_DROP: assert property (
        i_wr_en && (wr_tgt != CFR_TGT_NONE) && !i_rd_en
        |=> o_wr_drop && !o_rd_valid && $stable(o_rd_data))
        else $error("mapped write not dropped cleanly");

    AST_MISS_ZERO: assert property (
        i_rd_en && (rd_tgt == CFR_TGT_NONE)
        |=> o_rd_valid && !o_rd_hit && o_rd_data == '0)
        else $error("unmapped read not zero");

    AST_IDLE_HOLD: assert property (
        !i_rd_en |=> !o_rd_valid && $stable(o_rd_data))
        else $error("answer moved without a read");

    // Further checks; only the number and select misses decode the raw ports, the other decoding checks use the shared function

    AST_RST_QUIET: assert property (
        @(posedge i_sys_clk) disable iff (1'b0)
        !rstn_sync |-> (o_rd_data == '0) && !o_rd_valid && !o_rd_hit
            && !o_wr_drop)
        else $error("outputs not quiet in reset");

    AST_VALID_PULSE: assert property (
        i_rd_en |=> o_rd_valid)
        else $error("read not answered after one cycle");

    AST_HIT_NEEDS_VALID: assert property (
        o_rd_hit |-> o_rd_valid)
        else $error("hit shown without a valid answer");

    AST_WORD_ONE: assert property (
        rd_one |=> o_rd_hit && (o_rd_data == CFR_WORD_ONE))
        else $error("first word read wrong");

    AST_WORD_THREE: assert property (
        rd_three |=> o_rd_hit && (o_rd_data == CFR_WORD_THREE))
        else $error("third word read wrong");

    AST_NUM_MISS: assert property (
        i_rd_en && (i_rd_num != CFR_FEAT_REG_NUM) |=> !o_rd_hit)
        else $error("foreign register number read as hit");

    AST_SEL_MISS: assert property (
        i_rd_en && (i_rd_sel != CFR_SEL_WORD_ONE)
        && (i_rd_sel != CFR_SEL_WORD_THREE) |=> !o_rd_hit)
        else $error("foreign select read as hit");

    AST_WR_IDLE: assert property (
        !i_wr_en |=> !o_wr_drop)
        else $error("drop flagged without a write");

    AST_WR_NUM_MISS: assert property (
        i_wr_en && (i_wr_num != CFR_FEAT_REG_NUM) |=> !o_wr_drop)
        else $error("foreign register write flagged");

    AST_WR_SEL_MISS: assert property (
        i_wr_en && (i_wr_sel != CFR_SEL_WORD_ONE)
        && (i_wr_sel != CFR_SEL_WORD_THREE) |=> !o_wr_drop)
        else $error("foreign select write flagged");

    AST_WR_SAME_CYCLE: assert property (
        i_wr_en && (wr_tgt == CFR_TGT_THREE) && rd_three
        |=> o_wr_drop && (o_rd_data == CFR_WORD_THREE))
        else $error("write beside a read altered the third word");

    AST_WR_BEFORE_THREE: assert property (
        (i_wr_en && (wr_tgt == CFR_TGT_THREE)) ##1 rd_three
        |=> o_rd_data == CFR_WORD_THREE)
        else $error("write altered the third word");

    CV_READ_ONE: cover property (s_one);

    CV_READ_THREE: cover property (s_three);

    CV_WRITE_THEN_READ: cover property (
        (i_wr_en && (wr_tgt == CFR_TGT_THREE)) ##1 rd_three ##1 o_rd_hit);

    CV_MISS: cover property (i_rd_en && (rd_tgt == CFR_TGT_NONE));

    CV_WRITE_WITH_READ: cover property (
        i_wr_en && (wr_tgt == CFR_TGT_THREE) && rd_three);

endmodule

// ===== tb/cfr_core_feature_readback_tb.sv
module cfr_core_feature_readback_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import cfr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Stimulus and observed signals
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_rd_en = 1'b0;
    logic [CFR_NUM_W-1:0] i_rd_num = 5'h00;
    logic [CFR_SEL_W-1:0] i_rd_sel = 3'h0;
    logic i_wr_en = 1'b0;
    logic [CFR_NUM_W-1:0] i_wr_num = 5'h00;
    logic [CFR_SEL_W-1:0] i_wr_sel = 3'h0;
    logic [CFR_DATA_W-1:0] i_wr_data = 32'h0000_0000;
    logic [CFR_DATA_W-1:0] o_rd_data;
    logic o_rd_valid;
    logic o_rd_hit;
    logic o_wr_drop;
    int failures = 0;
    int num_checks = 0;
    logic [31:0] seed = 32'h566F_D261;
    logic [31:0] exp_one = 32'h0000_0000;
    logic [31:0] exp_three = 32'h0000_0000;
    logic [31:0] exp_data = 32'h0000_0000;
    logic [31:0] exp_q[$];

    always #12.5 i_sys_clk = ~i_sys_clk;

    cfr_top dut (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_rd_en(i_rd_en),
        .i_rd_num(i_rd_num),
        .i_rd_sel(i_rd_sel),
        .i_wr_en(i_wr_en),
        .i_wr_num(i_wr_num),
        .i_wr_sel(i_wr_sel),
        .i_wr_data(i_wr_data),
        .o_rd_data(o_rd_data),
        .o_rd_valid(o_rd_valid),
        .o_rd_hit(o_rd_hit),
        .o_wr_drop(o_wr_drop)
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Model of one field; bits not written stay zero
    task automatic put(input int w, input int hi, input int lo, input int v);
        for (int b = lo; b <= hi; b++) begin
            if (w == 1) begin
                exp_one[b] = v[b-lo];
            end else begin
                exp_three[b] = v[b-lo];
            end
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic done_test(input string name);
        $display("test %s done, checks=%0d", name, num_checks);
    endtask

    // One cycle of traffic; the answers are judged one edge later
    task automatic cyc(input logic re, input logic [4:0] rn,
        input logic [2:0] rs, input logic we, input logic [4:0] wn,
        input logic [2:0] ws, input logic [31:0] wd);
        logic hit;
        logic drop;
        hit = (rn == CFR_FEAT_REG_NUM) && (rs == 3'h1 || rs == 3'h3);
        drop = we && (wn == CFR_FEAT_REG_NUM) && (ws == 3'h1 || ws == 3'h3);
        if (re) begin
            exp_q.push_back(!hit ? 32'h0
                : (rs == 3'h1 ? exp_one : exp_three));
        end
        i_rd_en = re;
        i_rd_num = rn;
        i_rd_sel = rs;
        i_wr_en = we;
        i_wr_num = wn;
        i_wr_sel = ws;
        i_wr_data = wd;
        @(posedge i_sys_clk);
        #2;
        if (re) begin
            exp_data = exp_q.pop_front();
        end
        chk({31'h0, o_rd_valid}, {31'h0, re});
        chk({31'h0, o_rd_hit}, {31'h0, re && hit});
        chk({31'h0, o_wr_drop}, {31'h0, drop});
        chk(o_rd_data, exp_data);
    endtask

    task automatic idle(input int n);
        repeat (n) cyc(1'b0, 5'h00, 3'h0, 1'b0, 5'h00, 3'h0, 32'h0);
    endtask

    task automatic reset_phase(input int n);
        i_rstn = 1'b0;
        repeat (n) @(posedge i_sys_clk);
        #2;
        exp_data = 32'h0;
        exp_q.delete();
        chk({o_rd_data[31:1], o_rd_data[0] | o_rd_valid | o_rd_hit
            | o_wr_drop}, 32'h0);
        i_rstn = 1'b1;
        idle(3);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        #100_000;
        failures++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] r;
        put(1, 31, 31, 1);
        put(1, 30, 5, 0);
        put(1, 4, 4, 1);
        put(1, 3, 3, 0);
        put(1, 2, 2, 0);
        put(1, 1, 1, 1);
        put(1, 0, 0, 0);
        put(3, 31, 31, 0);
        put(3, 22, 21, 1);
        put(3, 20, 18, 0);
        put(3, 17, 17, 1);
        put(3, 16, 16, 1);
        put(3, 15, 14, 1);
        put(3, 13, 13, 1);
        put(3, 12, 12, 1);
        put(3, 8, 8, 0);
        put(3, 6, 6, 1);
        put(3, 5, 5, 1);
        put(3, 4, 4, 0);
        put(3, 3, 3, 1);
        put(3, 0, 0, 0);
        reset_phase(12);
        done_test("reset");
        // Back to back over every select, then neighbouring numbers
        for (int s = 0; s < 8; s++) begin
            cyc(1'b1, 5'h10, 3'(s), 1'b0, 5'h00, 3'h0, 32'h0);
        end
        cyc(1'b1, 5'h10, 3'h3, 1'b0, 5'h00, 3'h0, 32'h0);
        cyc(1'b1, 5'h0F, 3'h1, 1'b0, 5'h00, 3'h0, 32'h0);
        cyc(1'b1, 5'h11, 3'h3, 1'b0, 5'h00, 3'h0, 32'h0);
        cyc(1'b1, 5'h10, 3'h1, 1'b0, 5'h00, 3'h0, 32'h0);
        idle(2);
        done_test("reads");
        // Writes of all ones and of random data, each but the foreign-number write with a read beside it
        for (int s = 0; s < 8; s++) begin
            cyc(1'b1, 5'h10, 3'(s), 1'b1, 5'h10, 3'(s),
                32'hFFFF_FFFF);
            cyc(1'b1, 5'h10, 3'(s ^ 2), 1'b1, 5'h10, 3'(s), xs());
        end
        cyc(1'b0, 5'h00, 3'h0, 1'b1, 5'h0F, 3'h1, xs());
        cyc(1'b1, 5'h10, 3'h1, 1'b1, 5'h10, 3'h3, xs());
        cyc(1'b1, 5'h10, 3'h3, 1'b0, 5'h00, 3'h0, 32'h0);
        done_test("writes");
        // Random mixed traffic, biased towards the feature words
        repeat (400) begin
            r = xs();
            cyc(r[0], r[1] ? 5'h10 : r[8:4], r[11:9], r[2],
                r[3] ? 5'h10 : r[16:12], r[19:17], xs());
        end
        done_test("random");
        // Reset in mid-run, after data was left on the read port
        cyc(1'b1, 5'h10, 3'h3, 1'b1, 5'h10, 3'h3, xs());
        reset_phase(2);
        cyc(1'b1, 5'h10, 3'h3, 1'b1, 5'h10, 3'h1, xs());
        cyc(1'b1, 5'h10, 3'h1, 1'b1, 5'h10, 3'h1, xs());
        idle(2);
        done_test("midreset");
        complete_run();
    end
endmodule
